// file: test/shp_command_port_properties.sv
`timescale 1ns/1ps
`default_nettype none
module shp_command_port_properties import shp_pkg::*; (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Serial pins
    input wire logic host_select_n,
    input wire logic serialDataOutEn,
    input wire logic sdaOut,
    // Core side
    input wire logic playActive,
    input wire logic playStandby,
    input wire logic cmdDone,
    input wire logic [7:0] cmdByte,
    input wire logic cmdValid,
    input wire logic cmd_busy_pin_n,
    input wire logic activity_flag_n,
    input wire logic channel_ready_flag_n
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    ////////////////////////////////////////////////////////////////////////
    // Select held long enough to clear the pin synchroniser
    sequence s_held(logic v);
        (host_select_n == v) [*5];
    endsequence

    a_drive_selected: assert property (s_held(1'b0) |-> serialDataOutEn)
        else $error("status output idle while selected");
    a_float_deselect: assert property (s_held(1'b1) |-> !serialDataOutEn)
        else $error("status output driven while deselected");
    a_valid_pulse: assert property (cmdValid |=> !cmdValid)
        else $error("execute strobe longer than one cycle");
    a_byte_hold: assert property (!cmdValid |-> $stable(cmdByte))
        else $error("command byte changed without execute");
    a_busy_fall: assert property (cmdValid |-> ##[0:1] !cmd_busy_pin_n)
        else $error("busy pin not low after execute");
    a_busy_rise: assert property ($rose(cmd_busy_pin_n) |-> $past(cmdDone))
        else $error("busy pin released without completion");
    // Leading cycle keeps the past values clear of reset
    a_activity_flag: assert property (1 |=>
        activity_flag_n == ($past(cmd_busy_pin_n) && !$past(playActive)))
        else $error("activity flag wrong");
    a_ready_flag: assert property (1 |=>
        channel_ready_flag_n == ($past(cmd_busy_pin_n) && !$past(playStandby)))
        else $error("ready flag wrong");
    // Open drain: the pin is only ever pulled low
    a_sda_low: assert property (!sdaOut)
        else $error("data line driven high");
endmodule // shp_command_port_properties

bind shp_command_port shp_command_port_properties chk (.*);
`default_nettype wire

// file: test/shp_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module shp_host_model import shp_pkg::*; (
    // Clock
    input wire logic clk,
    // Serial pins, host drives select, clock and data in
    output logic host_select_n,
    output logic serialClk,
    output logic serialDataIn,
    input wire logic edge_phase_select,
    input wire logic serialDataOut,
    input wire logic serialDataOutEn,
    // Two-wire bus, device only pulls low
    output logic sclIn,
    output logic sdaIn,
    input wire logic sdaOe
);
    // Quarter bit, just inside the fast-mode rate
    localparam int Q = 160;
    // Master's own data level, one is released
    logic sdaDrv = 1'b1;
    // Pull-up wins unless someone pulls low
    assign sdaIn = sdaDrv & ~sdaOe;

    initial begin
        host_select_n = 1'b1;
        serialClk = 1'b0;
        serialDataIn = 1'b0;
        sclIn = 1'b1;
    end

    ////////////////////////////////////////////////////////////////////////
    // Pins move on falling clk edges only
    task automatic idle(input int n);
        repeat (n) @(negedge clk);
    endtask

    // One serial frame; keep leaves select low for the next byte
    task automatic ser_xfer(input logic [7:0] cmd, input int nbits, input bit keep,
                            output logic [7:0] stat);
        stat = 8'h00;
        serialClk = edge_phase_select;
        idle(5);
        host_select_n = 1'b0;
        idle(5);
        for (int i = 0; i < nbits; i++) begin
            serialDataIn = cmd[7-i];
            idle(5);
            // Unknown if the device is not driving
            stat = {stat[6:0], serialDataOutEn ? serialDataOut : 1'bx};
            serialClk = ~edge_phase_select;
            idle(10);
            serialClk = edge_phase_select;
            idle(5);
        end
        // Released line shows no stale bit
        serialDataIn = ~serialDataIn;
        if (!keep) host_select_n = 1'b1;
        idle(10);
    endtask

    // One bus bit, sampled mid-high
    task automatic i2c_bit(input logic b, output logic r);
        sdaDrv = b;
        idle(Q);
        sclIn = 1'b1;
        idle(Q);
        r = sdaIn;
        idle(Q);
        sclIn = 1'b0;
        idle(Q);
    endtask

    // Byte plus acknowledge slot, master releases the slot
    task automatic i2c_byte(input logic [7:0] tx, output logic [7:0] rx, output logic ack);
        for (int i = 7; i >= 0; i--) i2c_bit(tx[i], rx[i]);
        i2c_bit(1'b1, ack);
    endtask

    // Start, address, one data byte, stop; a read ends in a master nack
    task automatic i2c_xfer(input logic [7:0] addr, input logic [7:0] data,
                            output logic [7:0] rd, output logic [1:0] acks);
        logic [7:0] junk;
        sdaDrv = 1'b0;
        idle(Q);
        sclIn = 1'b0;
        idle(Q);
        i2c_byte(addr, junk, acks[1]);
        i2c_byte(addr[0] ? 8'hff : data, rd, acks[0]);
        sdaDrv = 1'b0;
        idle(Q);
        sclIn = 1'b1;
        idle(Q);
        sdaDrv = 1'b1;
        idle(Q);
    endtask
endmodule // shp_host_model
`default_nettype wire

// file: test/speech_host_command_port_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module speech_host_command_port_tb_top import shp_pkg::*; ();
    // Row: phase, command, core levels, expected status
    typedef struct packed {
        logic ph;
        logic [7:0] cmd;
        logic pa;
        logic ps;
        logic [7:0] stat;
    } shp_row_t;
    shp_row_t rows [4] = '{'{1'b0, 8'ha5, 1'b0, 1'b0, 8'h21}, '{1'b1, 8'h3c, 1'b1, 1'b0, 8'h01},
        '{1'b0, 8'h81, 1'b0, 1'b1, 8'h20}, '{1'b1, 8'h7e, 1'b1, 1'b1, 8'h00}};
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic edge_phase_select = 1'b0, playActive = 1'b0, playStandby = 1'b0, cmdDone = 1'b0;
    // Straps give upper address bits 101
    logic addr_strap_bit_a = 1'b1, addr_strap_bit_b = 1'b0, addr_strap_bit_c = 1'b1;
    logic host_select_n, serialClk, serialDataIn, serialDataOut, serialDataOutEn;
    logic sclIn, sdaIn, sdaOut, sdaOe, cmdValid, cmd_busy_pin_n;
    logic activity_flag_n, channel_ready_flag_n;
    logic [7:0] cmdByte, gotByte = 8'h00;
    int gotCnt = 0, fails = 0, tests_run = 0;

    shp_command_port DUT (.clk, .rst_n, .host_select_n, .serialClk, .serialDataIn,
        .edge_phase_select, .serialDataOut, .serialDataOutEn, .sclIn, .sdaIn, .sdaOut, .sdaOe,
        .addr_strap_bit_a, .addr_strap_bit_b, .addr_strap_bit_c, .playActive, .playStandby,
        .cmdDone, .cmdByte, .cmdValid, .cmd_busy_pin_n, .activity_flag_n,
        .channel_ready_flag_n);
    shp_host_model host (.clk, .host_select_n, .serialClk, .serialDataIn, .edge_phase_select,
        .serialDataOut, .serialDataOutEn, .sclIn, .sdaIn, .sdaOe);

    initial forever #2 clk = ~clk;
    // Core stand-in: records each execute, finishes it 60 cycles later
    // Looks mid-cycle so the strobe and byte are settled, not racing the edge
    initial forever begin
        @(negedge clk iff cmdValid === 1'b1);
        gotCnt++;
        gotByte = cmdByte;
        repeat (60) @(negedge clk);
        cmdDone = 1'b1;
        @(negedge clk);
        cmdDone = 1'b0;
    end
    // Watchdog well past the two-wire traffic, about 197 us of it
    initial begin
        #300000;
        fails++;
        end_sim();
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic end_sim;
        $display("Checks %0d, mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    initial begin
        logic [7:0] st;
        logic [1:0] ak;
        int n;
        repeat (5) @(negedge clk);
        check({4'h0, serialDataOutEn, cmd_busy_pin_n, activity_flag_n, sdaOe}, 8'h06);
        check(cmdByte, 8'h00);
        rst_n = 1'b1;
        repeat (4) @(negedge clk);
        foreach (rows[i]) begin
            edge_phase_select = rows[i].ph;
            playActive = rows[i].pa;
            playStandby = rows[i].ps;
            n = gotCnt;
            repeat (10) @(negedge clk);
            host.ser_xfer(rows[i].cmd, 8, 1'b0, st);
            check(st, rows[i].stat);
            check(gotByte, rows[i].cmd);
            check(8'(gotCnt - n), 8'h01);
            check({5'h0, cmd_busy_pin_n, activity_flag_n, channel_ready_flag_n}, 8'h00);
            repeat (80) @(negedge clk);
            check({6'h0, cmd_busy_pin_n, activity_flag_n}, {7'h1, ~rows[i].pa});
            check({7'h0, channel_ready_flag_n}, {7'h0, ~rows[i].ps});
        end
        // Partial byte dropped when select rises mid-byte
        n = gotCnt;
        host.ser_xfer(8'hff, 3, 1'b0, st);
        host.ser_xfer(8'h42, 8, 1'b0, st);
        check(gotByte, 8'h42);
        repeat (80) @(negedge clk);
        // Two bytes under one unbroken select
        host.ser_xfer(8'h5a, 8, 1'b1, st);
        repeat (80) @(negedge clk);
        host.ser_xfer(8'hc3, 8, 1'b0, st);
        check(gotByte, 8'hc3);
        check(8'(gotCnt - n), 8'h03);
        repeat (80) @(negedge clk);
        // Two-wire read before any snapshot gives the reset value
        playActive = 1'b1;
        playStandby = 1'b0;
        host.i2c_xfer({3'b101, SHP_ADDR_LOW, 1'b1}, 8'h00, st, ak);
        check(st, SHP_STATUS_IDLE);
        check({7'h0, ak[1]}, 8'h00);
        host.i2c_xfer({3'b101, SHP_ADDR_LOW, 1'b0}, SHP_SNAPSHOT_CMD, st, ak);
        check({6'h0, ak}, 8'h00);
        check(gotByte, SHP_SNAPSHOT_CMD);
        repeat (80) @(negedge clk);
        host.i2c_xfer({3'b101, SHP_ADDR_LOW, 1'b1}, 8'h00, st, ak);
        check(st & 8'hfe, 8'h00);
        // Foreign address: no acknowledge, nothing executed
        n = gotCnt;
        host.i2c_xfer({3'b010, SHP_ADDR_LOW, 1'b0}, 8'h77, st, ak);
        check({6'h0, ak}, 8'h03);
        check(8'(gotCnt - n), 8'h00);
        end_sim();
    end
endmodule // speech_host_command_port_tb_top
`default_nettype wire

// file: verilog/shp_command_port.sv
`timescale 1ns/1ps
`default_nettype none
module shp_command_port import shp_pkg::*; (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Three-wire serial pins
    input wire logic host_select_n,
    input wire logic serialClk,
    input wire logic serialDataIn,
    input wire logic edge_phase_select,
    output logic serialDataOut,
    output logic serialDataOutEn,
    // Two-wire pins, open drain
    input wire logic sclIn,
    input wire logic sdaIn,
    output logic sdaOut,
    output logic sdaOe,
    input wire logic addr_strap_bit_a,
    input wire logic addr_strap_bit_b,
    input wire logic addr_strap_bit_c,
    // Playback core side
    input wire logic playActive,
    input wire logic playStandby,
    input wire logic cmdDone,
    output logic [7:0] cmdByte,
    output logic cmdValid,
    output logic cmd_busy_pin_n,
    output logic activity_flag_n,
    output logic channel_ready_flag_n
);

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers

    localparam int NSYNC = 10;

    logic [NSYNC-1:0] pinRaw; // Raw pin levels
    logic [NSYNC-1:0] syncA_reg; // First stage, read only by second
    logic [NSYNC-1:0] syncB_reg; // Safe levels
    logic [NSYNC-1:0] syncC_reg; // Previous safe levels, for edges

    assign pinRaw = {host_select_n, serialClk, serialDataIn, edge_phase_select,
                     sclIn, sdaIn, addr_strap_bit_c, addr_strap_bit_b,
                     addr_strap_bit_a, 1'b0};

    // Two flops per pin, a third for edge finding
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            syncA_reg <= '1;
            syncB_reg <= '1;
            syncC_reg <= '1;
        end else begin
            syncA_reg <= pinRaw;
            syncB_reg <= syncA_reg;
            syncC_reg <= syncB_reg;
        end
    end

    logic selN; // Select, synchronised
    logic sckNow; // Serial clock now
    logic sckPrev; // Serial clock one cycle ago
    logic siNow; // Serial data, same delay as clock
    logic phaseSel; // Edge phase select
    logic sclNow;
    logic sclPrev;
    logic sdaNow;
    logic sdaPrev;
    logic [2:0] straps; // c, b, a top down

    assign selN = syncB_reg[9];
    assign sckNow = syncB_reg[8];
    assign sckPrev = syncC_reg[8];
    assign siNow = syncB_reg[7];
    assign phaseSel = syncB_reg[6];
    assign sclNow = syncB_reg[5];
    assign sclPrev = syncC_reg[5];
    assign sdaNow = syncB_reg[4];
    assign sdaPrev = syncC_reg[4];
    assign straps = syncB_reg[3:1];

    ////////////////////////////////////////////////////////////////////////
    // Live status

    shp_core_t core_reg;
    shp_core_t core_next;
    logic [7:0] statusLive; // Status byte from current flags

    // Undefined bits read as zero
    always_comb begin
        statusLive = 8'h00;
        statusLive[SHP_BUSY_BIT] = core_reg.busyN;
        statusLive[SHP_READY_BIT] = core_reg.readyN;
    end

    ////////////////////////////////////////////////////////////////////////
    // Three-wire serial port

    shp_serial_t ser_reg;
    shp_serial_t ser_next;
    logic sckRise;
    logic sckFall;
    logic sampleEdge; // Edge that shifts data in
    logic outEdge; // Edge that moves the status bit
    logic serExec; // Byte complete this cycle
    logic [7:0] serByte;

    assign sckRise = sckNow & ~sckPrev;
    assign sckFall = ~sckNow & sckPrev;
    assign sampleEdge = phaseSel ? sckFall : sckRise;
    assign outEdge = phaseSel ? sckRise : sckFall;

    // Counts clock edges only while selected
    always_comb begin
        ser_next = ser_reg;
        serExec = 1'b0;
        serByte = {ser_reg.shiftIn[6:0], siNow};
        ser_next.dataOutEn = ~selN;
        if (selN) begin
            // Idle: clear count, preload status so MSB is ready at select fall
            ser_next.bitCount = 3'h0;
            ser_next.shiftOut = statusLive;
            ser_next.dataOut = statusLive[7];
        end else begin
            if (sampleEdge) begin
                ser_next.shiftIn = serByte;
                ser_next.bitCount = ser_reg.bitCount + 3'h1;
                serExec = (ser_reg.bitCount == SHP_LAST_BIT);
            end
            if (outEdge) begin
                // Status goes MSB first, zeros after the byte
                ser_next.shiftOut = {ser_reg.shiftOut[6:0], 1'b0};
                ser_next.dataOut = ser_reg.shiftOut[6];
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ser_reg <= '{bitCount: 3'h0, shiftIn: 8'h00, shiftOut: SHP_STATUS_IDLE,
                         dataOut: 1'b0, dataOutEn: 1'b0};
        end else begin
            ser_reg <= ser_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Two-wire slave

    shp_i2c_t iic_reg;
    shp_i2c_t iic_next;
    logic sclRise;
    logic sclFall;
    logic startCond;
    logic stopCond;
    logic iicExec; // Data byte complete this cycle
    logic [7:0] iicByte;

    // Slow fast-mode edges are many clock cycles apart, so sampling suffices
    assign sclRise = sclNow & ~sclPrev;
    assign sclFall = ~sclNow & sclPrev;
    assign startCond = sclNow & sclPrev & sdaPrev & ~sdaNow;
    assign stopCond = sclNow & sclPrev & ~sdaPrev & sdaNow;

    always_comb begin
        iic_next = iic_reg;
        iicExec = 1'b0;
        iicByte = {iic_reg.shiftReg[6:0], sdaNow};
        iic_next.sdaOut = 1'b0;
        if (startCond) begin
            // Start or repeated start from any phase
            iic_next.phase = I2C_ADDR;
            iic_next.bitCount = 3'h0;
            iic_next.firstByte = 1'b1;
            iic_next.handover = 1'b0;
            iic_next.sdaOe = 1'b0;
        end else if (stopCond) begin
            iic_next.phase = I2C_IDLE;
            iic_next.sdaOe = 1'b0;
        end else begin
            unique case (iic_reg.phase)
                I2C_IDLE: begin
                    iic_next.sdaOe = 1'b0;
                end
                I2C_ADDR, I2C_WRITE: begin
                    if (sclRise) begin
                        iic_next.shiftReg = iicByte;
                        iic_next.bitCount = iic_reg.bitCount + 3'h1;
                        if (iic_reg.bitCount == SHP_LAST_BIT) begin
                            iic_next.handover = 1'b0;
                            if (iic_reg.phase == I2C_ADDR) begin
                                // Wrong address: stay off the bus
                                iic_next.readDir = iicByte[0];
                                iic_next.phase = (iicByte[7:1] == {straps, SHP_ADDR_LOW})
                                               ? I2C_ACK : I2C_IDLE;
                            end else begin
                                iicExec = 1'b1;
                                iic_next.phase = I2C_ACK;
                                iic_next.firstByte = 1'b0;
                                if (iic_reg.firstByte && iicByte == SHP_SNAPSHOT_CMD) begin
                                    iic_next.snapshot = statusLive;
                                end
                            end
                        end
                    end
                end
                I2C_ACK: begin
                    // First fall pulls low, second fall releases for a write or drives the snapshot MSB for a read
                    if (sclFall) begin
                        if (!iic_reg.handover) begin
                            iic_next.sdaOe = 1'b1;
                            iic_next.handover = 1'b1;
                        end else begin
                            iic_next.handover = 1'b0;
                            iic_next.bitCount = 3'h0;
                            if (iic_reg.readDir) begin
                                iic_next.phase = I2C_READ;
                                iic_next.shiftReg = iic_reg.snapshot;
                                iic_next.sdaOe = ~iic_reg.snapshot[7];
                            end else begin
                                iic_next.phase = I2C_WRITE;
                                iic_next.sdaOe = 1'b0;
                            end
                        end
                    end
                end
                I2C_READ: begin
                    if (sclRise) begin
                        iic_next.bitCount = iic_reg.bitCount + 3'h1;
                        if (iic_reg.bitCount == SHP_LAST_BIT) begin
                            iic_next.phase = I2C_READ_ACK;
                        end
                    end
                    if (sclFall && iic_reg.bitCount != 3'h0) begin
                        iic_next.shiftReg = {iic_reg.shiftReg[6:0], 1'b0};
                        iic_next.sdaOe = ~iic_reg.shiftReg[6];
                    end
                end
                I2C_READ_ACK: begin
                    // Master's acknowledge decides whether to resend status
                    if (sclRise) begin
                        if (sdaNow) begin
                            iic_next.phase = I2C_IDLE;
                        end else begin
                            iic_next.handover = 1'b1;
                        end
                    end
                    if (sclFall) begin
                        if (iic_reg.handover) begin
                            iic_next.handover = 1'b0;
                            iic_next.phase = I2C_READ;
                            iic_next.bitCount = 3'h0;
                            iic_next.shiftReg = iic_reg.snapshot;
                            iic_next.sdaOe = ~iic_reg.snapshot[7];
                        end else begin
                            iic_next.sdaOe = 1'b0;
                        end
                    end
                end
                default: begin
                    iic_next.phase = I2C_IDLE;
                    iic_next.sdaOe = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            iic_reg <= '{phase: I2C_IDLE, bitCount: 3'h0, shiftReg: 8'h00,
                         firstByte: 1'b0, readDir: 1'b0, handover: 1'b0,
                         sdaOut: 1'b0, sdaOe: 1'b0, snapshot: SHP_STATUS_IDLE};
        end else begin
            iic_reg <= iic_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Command hand-off and flags

    // Serial wins a same-cycle clash; host pacing on the busy pin avoids it
    always_comb begin
        core_next = core_reg;
        core_next.cmdValid = serExec | iicExec;
        if (serExec) begin
            core_next.cmdByte = serByte;
        end else if (iicExec) begin
            core_next.cmdByte = iicByte;
        end
        // New command wins over a done pulse in the same cycle
        if (serExec || iicExec) begin
            core_next.cmdBusyN = 1'b0;
        end else if (cmdDone) begin
            core_next.cmdBusyN = 1'b1;
        end
        core_next.busyN = ~(~core_reg.cmdBusyN | playActive);
        core_next.readyN = ~(~core_reg.cmdBusyN | playStandby);
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            core_reg <= '{cmdByte: 8'h00, cmdValid: 1'b0, cmdBusyN: 1'b1,
                          busyN: 1'b1, readyN: 1'b1};
        end else begin
            core_reg <= core_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs, all straight from flops

    assign serialDataOut = ser_reg.dataOut;
    assign serialDataOutEn = ser_reg.dataOutEn;
    assign sdaOut = iic_reg.sdaOut;
    assign sdaOe = iic_reg.sdaOe;
    assign cmdByte = core_reg.cmdByte;
    assign cmdValid = core_reg.cmdValid;
    assign cmd_busy_pin_n = core_reg.cmdBusyN;
    assign activity_flag_n = core_reg.busyN;
    assign channel_ready_flag_n = core_reg.readyN;

endmodule // shp_command_port
`default_nettype wire

// file: verilog/shp_pkg.sv
`default_nettype none
package shp_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Constants

    // Fixed low nibble of the two-wire slave address
    localparam logic [3:0] SHP_ADDR_LOW = 4'h5;
    // Command that refreshes the readable status snapshot
    localparam logic [7:0] SHP_SNAPSHOT_CMD = 8'hb0;
    // Status byte field positions
    localparam int SHP_BUSY_BIT = 5;
    localparam int SHP_READY_BIT = 0;
    // Bit index of the last bit of a byte
    localparam logic [2:0] SHP_LAST_BIT = 3'h7;
    // Status byte while idle: both flags high
    localparam logic [7:0] SHP_STATUS_IDLE = 8'h21;

    ////////////////////////////////////////////////////////////////////////
    // Types

    // Two-wire slave phases
    typedef enum logic [2:0] {
        I2C_IDLE,
        I2C_ADDR,
        I2C_ACK,
        I2C_WRITE,
        I2C_READ,
        I2C_READ_ACK
    } shp_i2c_phase_t;

    // Three-wire port state
    typedef struct packed {
        logic [2:0] bitCount;
        logic [7:0] shiftIn;
        logic [7:0] shiftOut;
        logic dataOut;
        logic dataOutEn;
    } shp_serial_t;

    // Two-wire slave state
    typedef struct packed {
        shp_i2c_phase_t phase;
        logic [2:0] bitCount;
        logic [7:0] shiftReg;
        logic firstByte;
        logic readDir;
        logic handover;
        logic sdaOut;
        logic sdaOe;
        logic [7:0] snapshot;
    } shp_i2c_t;

    // Shared command and status state
    typedef struct packed {
        logic [7:0] cmdByte;
        logic cmdValid;
        logic cmdBusyN;
        logic busyN;
        logic readyN;
    } shp_core_t;

endpackage
`default_nettype wire
